// ==== design/ufd_pkg.sv ====
// Shared constants of the serial transceiver FIFO and request block.
// Assumes a 32-bit classic Wishbone register bus, one word per register.
package ufd_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_DATA   = 8'h00;
	localparam logic [7:0] ADR_IER    = 8'h04;
	localparam logic [7:0] ADR_IIR    = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0c;
	localparam logic [7:0] ADR_DIV    = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FCR_EN       = 0;
	localparam int FCR_RX_CLR   = 1;
	localparam int FCR_TX_CLR   = 2;
	localparam int FCR_DMA      = 3;
	localparam int FCR_TRIG_LO  = 6;
	localparam int IER_RX       = 0;
	localparam int IER_TX       = 1;
	localparam int ST_OVERRUN   = 0;
	localparam int ST_TX_FULL   = 1;
	localparam int ST_RX_EMPTY  = 2;
	localparam int ST_TX_IDLE   = 3;
	localparam int ST_RX_CNT_LO = 8;
	localparam int ST_TX_CNT_LO = 16;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  ID_NONE    = 4'h1;
	localparam logic [3:0]  ID_TX_EMPTY = 4'h2;
	localparam logic [3:0]  ID_RX_DATA = 4'h4;
	localparam logic [3:0]  ID_TIMEOUT = 4'hc;
	localparam logic [1:0]  FIFO_ON_ID = 2'h3;
	localparam logic [1:0]  TRIG_1     = 2'h0;
	localparam logic [1:0]  TRIG_4     = 2'h1;
	localparam logic [1:0]  TRIG_8     = 2'h2;
	localparam logic [4:0]  LVL_1      = 5'h01;
	localparam logic [4:0]  LVL_4      = 5'h04;
	localparam logic [4:0]  LVL_8      = 5'h08;
	localparam logic [4:0]  LVL_14     = 5'h0e;
	localparam logic [15:0] DIV_RESET  = 16'h0010;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [3:0] FRAME_BITS    = 4'ha;
	localparam int         TIMEOUT_CHARS = 4;
	localparam int         TIME_W        = 24;
endpackage

// ==== design/ufd_fifo.sv ====
// Byte FIFO with occupancy count and synchronous flush.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/10ps
module ufd_fifo #(
	parameter int W  = 8,
	parameter int D  = 16,
	parameter int CW = 5
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          flush_i,
	input  wire logic          push_i,
	input  wire logic [W-1:0]  din_i,
	input  wire logic          pop_i,
	output logic      [W-1:0]  dout_o,
	output logic      [CW-1:0] count_o
);
	localparam int PW = $clog2(D);
	localparam logic [PW-1:0] P_ONE = PW'(1);
	localparam logic [CW-1:0] C_ONE = CW'(1);

	logic [W-1:0]  mem [D];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [CW-1:0] cnt_r;

	assign dout_o  = mem[rp_r];
	assign count_o = cnt_r;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (push_i && !flush_i) begin
			mem[wp_r] <= din_i;
		end
	end

	// ----------------------------------------------------------------
	// Pointers and count
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push_i) begin
				wp_r <= wp_r + P_ONE;
			end
			if (pop_i) begin
				rp_r <= rp_r + P_ONE;
			end
			if (push_i && !pop_i) begin
				cnt_r <= cnt_r + C_ONE;
			end else if (pop_i && !push_i) begin
				cnt_r <= cnt_r - C_ONE;
			end
		end
	end
endmodule

// ==== design/ufd_top.sv ====
// Transmit and receive FIFOs, service requests and DMA request logic
// of an asynchronous serial transceiver, with a byte serialiser.
// Assumes a classic Wishbone master and a receive shift register that
// strobes each completed character on rx_valid_i.
`timescale 1ns/10ps
module ufd_top #(
	parameter int DEPTH = 16,
	parameter int CW    = 5
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	output logic             serial_out_o,
	output logic             intr_o,
	output logic             rx_dma_req_o,
	output logic             tx_dma_req_o
);
	localparam logic [CW-1:0] CAP      = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_SLOT = CW'(1);
	localparam logic [CW-1:0] TWO      = CW'(2);
	localparam int            TW       = ufd_pkg::TIME_W;
	localparam logic [TW-1:0] T_ONE    = TW'(1);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
		case (sel)
			ufd_pkg::TRIG_1: trig_level = CW'(ufd_pkg::LVL_1);
			ufd_pkg::TRIG_4: trig_level = CW'(ufd_pkg::LVL_4);
			ufd_pkg::TRIG_8: trig_level = CW'(ufd_pkg::LVL_8);
			default:         trig_level = CW'(ufd_pkg::LVL_14);
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic          ack_r;
	logic [31:0]   dat_r;
	logic [31:0]   rd_nxt;
	logic          fifo_en_r;
	logic          dma_mode_r;
	logic [1:0]    trig_sel_r;
	logic [1:0]    ier_r;
	logic [15:0]   div_r;
	logic          overrun_r;
	logic          req;
	logic          wr_go;
	logic          rd_go;
	logic          fcr_wr;
	logic          rx_flush;
	logic          tx_flush;
	logic [CW-1:0] limit;
	logic [CW-1:0] rx_cnt;
	logic [CW-1:0] tx_cnt;
	logic [7:0]    rx_dout;
	logic [7:0]    tx_dout;
	logic          rx_full;
	logic          tx_full;
	logic          rx_push;
	logic          rx_pop;
	logic          tx_push;
	logic          tx_pop;
	logic          rx_trig;
	logic [TW-1:0] char_cyc;
	logic [TW-1:0] to_cyc;
	logic [TW-1:0] to_cnt_r;
	logic          to_flag_r;
	logic          to_pend;
	logic [TW-1:0] txd_cnt_r;
	logic          two_seen_r;
	logic          tx_pend;
	logic          rx_pend;
	logic [3:0]    ident;
	logic          busy_r;
	logic [8:0]    shreg_r;
	logic [3:0]    bitcnt_r;
	logic [15:0]   baud_r;
	logic          serial_out_r;
	logic          intr_r;
	logic          rxreq_r;
	logic          txreq_r;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign req    = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_go  = req && wb_we_i && wb_sel_i[0];
	assign rd_go  = req && !wb_we_i;
	assign fcr_wr = wr_go && (wb_adr_i == ufd_pkg::ADR_IIR);
	assign rx_flush = fcr_wr && (wb_dat_i[ufd_pkg::FCR_RX_CLR] ||
		(wb_dat_i[ufd_pkg::FCR_EN] != fifo_en_r));
	assign tx_flush = fcr_wr && (wb_dat_i[ufd_pkg::FCR_TX_CLR] ||
		(wb_dat_i[ufd_pkg::FCR_EN] != fifo_en_r));

	// Without FIFOs each side acts as a single holding register
	assign limit   = fifo_en_r ? CAP : ONE_SLOT;
	assign rx_full = (rx_cnt >= limit);
	assign tx_full = (tx_cnt >= limit);

	assign rx_push = rx_valid_i && !rx_full;
	assign rx_pop  = rd_go && (wb_adr_i == ufd_pkg::ADR_DATA) &&
		(rx_cnt != '0);
	assign tx_push = wr_go && (wb_adr_i == ufd_pkg::ADR_DATA) &&
		!tx_full;
	assign tx_pop  = !busy_r && (tx_cnt != '0);

	// ----------------------------------------------------------------
	// FIFOs
	// ----------------------------------------------------------------
	ufd_fifo #(.W(8), .D(DEPTH), .CW(CW)) u_rx_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (rx_flush),
		.push_i  (rx_push),
		.din_i   (rx_data_i),
		.pop_i   (rx_pop),
		.dout_o  (rx_dout),
		.count_o (rx_cnt)
	);

	ufd_fifo #(.W(8), .D(DEPTH), .CW(CW)) u_tx_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (tx_flush),
		.push_i  (tx_push),
		.din_i   (wb_dat_i[7:0]),
		.pop_i   (tx_pop),
		.dout_o  (tx_dout),
		.count_o (tx_cnt)
	);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_en_r  <= 1'b0;
			dma_mode_r <= 1'b0;
			trig_sel_r <= ufd_pkg::TRIG_1;
		end else if (fcr_wr) begin
			fifo_en_r  <= wb_dat_i[ufd_pkg::FCR_EN];
			dma_mode_r <= wb_dat_i[ufd_pkg::FCR_DMA];
			trig_sel_r <= wb_dat_i[ufd_pkg::FCR_TRIG_LO +: 2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ier_r <= '0;
		end else if (wr_go && (wb_adr_i == ufd_pkg::ADR_IER)) begin
			ier_r <= wb_dat_i[1:0];
		end
	end

	// Zero divisor would stall the shifter, so it is held at one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= ufd_pkg::DIV_RESET;
		end else if (wr_go && (wb_adr_i == ufd_pkg::ADR_DIV)) begin
			div_r[7:0] <= ((wb_dat_i[7:0] == 8'h00) && (wb_sel_i[1] ?
				(wb_dat_i[15:8] == 8'h00) : (div_r[15:8] == 8'h00))) ?
				8'h01 : wb_dat_i[7:0];
			if (wb_sel_i[1]) begin
				div_r[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// Set wins over the clear by a status read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overrun_r <= 1'b0;
		end else if (rx_valid_i && rx_full) begin
			overrun_r <= 1'b1;
		end else if (rd_go && (wb_adr_i == ufd_pkg::ADR_STATUS)) begin
			overrun_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Character time
	// ----------------------------------------------------------------
	assign char_cyc = TW'(div_r) * TW'(ufd_pkg::FRAME_BITS);
	assign to_cyc   = TW'(char_cyc * TW'(ufd_pkg::TIMEOUT_CHARS));

	// ----------------------------------------------------------------
	// Receive timeout
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || rx_push || rx_pop || rx_flush) begin
			to_cnt_r  <= '0;
			to_flag_r <= 1'b0;
		end else if (fifo_en_r && (rx_cnt != '0) && !to_flag_r) begin
			if (to_cnt_r == to_cyc - T_ONE) begin
				to_flag_r <= 1'b1;
			end else begin
				to_cnt_r <= to_cnt_r + T_ONE;
			end
		end
	end
	assign to_pend = to_flag_r && (rx_cnt != '0);

	// ----------------------------------------------------------------
	// Transmit empty delay
	// ----------------------------------------------------------------
	// Guards against a fresh empty edge while software is still loading
	always_ff @(posedge clk_i) begin
		if (rst_i || tx_flush) begin
			txd_cnt_r <= '0;
		end else if (tx_push && (tx_cnt == '0)) begin
			txd_cnt_r <= char_cyc;
		end else if (txd_cnt_r != '0) begin
			txd_cnt_r <= txd_cnt_r - T_ONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || tx_flush) begin
			two_seen_r <= 1'b0;
		end else if (tx_push && (tx_cnt == '0)) begin
			two_seen_r <= 1'b0;
		end else if (tx_cnt >= TWO) begin
			two_seen_r <= 1'b1;
		end
	end

	assign tx_pend = ier_r[ufd_pkg::IER_TX] && (tx_cnt == '0) &&
		(two_seen_r || (txd_cnt_r == '0));

	// ----------------------------------------------------------------
	// Interrupt identification
	// ----------------------------------------------------------------
	assign rx_trig = (rx_cnt >= (fifo_en_r ? trig_level(trig_sel_r) :
		ONE_SLOT));
	assign rx_pend = ier_r[ufd_pkg::IER_RX] && rx_trig;

	always_comb begin
		if (rx_pend) begin
			ident = ufd_pkg::ID_RX_DATA;
		end else if (ier_r[ufd_pkg::IER_RX] && to_pend) begin
			ident = ufd_pkg::ID_TIMEOUT;
		end else if (tx_pend) begin
			ident = ufd_pkg::ID_TX_EMPTY;
		end else begin
			ident = ufd_pkg::ID_NONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			intr_r <= 1'b0;
		end else begin
			intr_r <= (ident != ufd_pkg::ID_NONE);
		end
	end

	// ----------------------------------------------------------------
	// DMA requests
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxreq_r <= 1'b0;
		end else if (!dma_mode_r || !fifo_en_r) begin
			rxreq_r <= (rx_cnt != '0);
		end else if (rx_cnt == '0) begin
			rxreq_r <= 1'b0;
		end else if (rx_trig || to_pend) begin
			rxreq_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txreq_r <= 1'b0;
		end else if (!dma_mode_r || !fifo_en_r) begin
			txreq_r <= (tx_cnt == '0);
		end else begin
			txreq_r <= !tx_full;
		end
	end

	// ----------------------------------------------------------------
	// Serialiser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_r   <= 1'b0;
			shreg_r  <= '1;
			bitcnt_r <= '0;
			baud_r   <= '0;
			serial_out_r   <= 1'b1;
		end else if (tx_pop) begin
			busy_r   <= 1'b1;
			shreg_r  <= {1'b1, tx_dout};
			bitcnt_r <= ufd_pkg::FRAME_BITS - 4'h1;
			baud_r   <= div_r - 16'h0001;
			serial_out_r   <= 1'b0;
		end else if (busy_r) begin
			if (baud_r != '0) begin
				baud_r <= baud_r - 16'h0001;
			end else if (bitcnt_r == '0) begin
				busy_r <= 1'b0;
			end else begin
				serial_out_r   <= shreg_r[0];
				shreg_r  <= {1'b1, shreg_r[8:1]};
				bitcnt_r <= bitcnt_r - 4'h1;
				baud_r   <= div_r - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	always_comb begin
		rd_nxt = '0;
		case (wb_adr_i)
			ufd_pkg::ADR_DATA: begin
				rd_nxt[7:0] = rx_dout;
			end
			ufd_pkg::ADR_IER: begin
				rd_nxt[1:0] = ier_r;
			end
			ufd_pkg::ADR_IIR: begin
				rd_nxt[3:0] = ident;
				rd_nxt[7:6] = fifo_en_r ? ufd_pkg::FIFO_ON_ID : 2'h0;
			end
			ufd_pkg::ADR_STATUS: begin
				rd_nxt[ufd_pkg::ST_OVERRUN]  = overrun_r;
				rd_nxt[ufd_pkg::ST_TX_FULL]  = tx_full;
				rd_nxt[ufd_pkg::ST_RX_EMPTY] = (rx_cnt == '0);
				rd_nxt[ufd_pkg::ST_TX_IDLE]  = !busy_r && (tx_cnt == '0);
				rd_nxt[ufd_pkg::ST_RX_CNT_LO +: CW] = rx_cnt;
				rd_nxt[ufd_pkg::ST_TX_CNT_LO +: CW] = tx_cnt;
			end
			ufd_pkg::ADR_DIV: begin
				rd_nxt[15:0] = div_r;
			end
			default: begin
				rd_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= req;
			if (rd_go) begin
				dat_r <= rd_nxt;
			end
		end
	end

	assign wb_ack_o     = ack_r;
	assign wb_dat_o     = dat_r;
	assign serial_out_o = serial_out_r;
	assign intr_o       = intr_r;
	assign rx_dma_req_o = rxreq_r;
	assign tx_dma_req_o = txreq_r;
endmodule

// ==== tb/ufd_host.sv ====
// Wishbone host model issuing classic single cycles for the bench.
// Assumes every call starts right after a rising edge of clk_i.
`timescale 1ns/10ps
module ufd_host (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	int hangs = 0;

	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// Silent slave is counted, not waited on forever
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		@(posedge clk_i);
		while (ack_i !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50)
			hangs++;
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~d;
		@(posedge clk_i);
	endtask
endmodule

// ==== tb/ufd_top_assertions.sv ====
// Port-level checks of the FIFO and request block.
// Assumes one clock, synchronous reset; control writes shadowed here.
`timescale 1ns/10ps
module ufd_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        rx_valid_i,
	input wire logic [7:0]  rx_data_i,
	input wire logic        serial_out_o,
	input wire logic        intr_o,
	input wire logic        rx_dma_req_o,
	input wire logic        tx_dma_req_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// Shadow of control writes
	// ----------------------------------------------------------------
	logic       fen_r;
	logic       mode1_r;
	logic [1:0] ier_r;
	logic       take;
	logic       wr_data;
	logic       wr_ctl;
	logic       rd_data;
	logic       mode0;

	assign take    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_data = take & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == ufd_pkg::ADR_DATA);
	assign wr_ctl  = take & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == ufd_pkg::ADR_IIR);
	assign rd_data = take & ~wb_we_i & (wb_adr_i == ufd_pkg::ADR_DATA);
	assign mode0   = ~mode1_r | ~fen_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fen_r   <= 1'b0;
			mode1_r <= 1'b0;
		end else if (wr_ctl) begin
			fen_r   <= wb_dat_i[ufd_pkg::FCR_EN];
			mode1_r <= wb_dat_i[ufd_pkg::FCR_DMA];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ier_r <= 2'h0;
		else if (take & wb_we_i & wb_sel_i[0]
			& (wb_adr_i == ufd_pkg::ADR_IER))
			ier_r <= wb_dat_i[1:0];
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held past one cycle");
	property p_ack_answer;
		take |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("access not answered next cycle");
	property p_tx_req_drop;
		wr_data && tx_dma_req_o && mode0 |-> ##2 !tx_dma_req_o;
	endproperty
	a_tx_req_drop: assert property (p_tx_req_drop)
		else $error("tx request stayed up after load");
	property p_rx_req_rise;
		rx_valid_i && !rx_dma_req_o && mode0 && !wr_ctl |-> ##2 rx_dma_req_o;
	endproperty
	a_rx_req_rise: assert property (p_rx_req_rise)
		else $error("rx request missing after char");
	property p_rx_req_fall;
		$fell(rx_dma_req_o) |-> $past(rd_data, 2) || $past(wr_ctl, 2);
	endproperty
	a_rx_req_fall: assert property (p_rx_req_fall)
		else $error("rx request fell without drain");
	// Holds for one character time at any divisor, since it is >= 10
	property p_tx_intr_hold;
		wr_data && intr_o && ier_r == 2'h2 |-> ##2 !intr_o [*8];
	endproperty
	a_tx_intr_hold: assert property (p_tx_intr_hold)
		else $error("tx interrupt not held off");
	// Bound only covers divisors up to 100
	property p_start_bit;
		wr_data && tx_dma_req_o && mode0 |-> ##[1:1000] !serial_out_o;
	endproperty
	a_start_bit: assert property (p_start_bit)
		else $error("no start bit after load");
	property p_iir_bits;
		take && !wb_we_i && wb_adr_i == ufd_pkg::ADR_IIR
			|=> wb_dat_o[7:6] == {2{fen_r}};
	endproperty
	a_iir_bits: assert property (p_iir_bits)
		else $error("ident bits do not follow enable");
endmodule

bind ufd_top ufd_checker chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i),
	.rx_data_i(rx_data_i), .serial_out_o(serial_out_o), .intr_o(intr_o),
	.rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o));

// ==== tb/test_uart_fifo_dma_request_logic.sv ====
// Self-checking bench of the FIFO and request block.
// Assumes the package, design, host model and checker compile first.
`timescale 1ns/10ps
`define CHK(n, e, s) begin \
	n_compared++; \
	if ((s) !== (e)) begin \
		fails++; \
		$display("BAD %s exp %0h got %0h", n, e, s); \
	end \
end
module test_uart_fifo_dma_request_logic;
	logic        clk_i      = 1'b0;
	logic        rst_i      = 1'b1;
	logic        rx_valid_i = 1'b0;
	logic [7:0]  rx_data_i  = 8'h00;
	logic        cyc, stb, we, ack, serial_out, intr, rxreq, txreq;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [7:0]  d;
	logic [7:0]  rxq[$];
	int          lvl[4] = '{1, 4, 8, 14};
	int          fails = 0;
	int          n_compared = 0;
	int          n;

	always #5 clk_i = ~clk_i;

	ufd_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.serial_out_o(serial_out), .intr_o(intr), .rx_dma_req_o(rxreq),
		.tx_dma_req_o(txreq));
	ufd_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

	task automatic close_out;
		fails += host.hangs;
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		host.xfer(1'b1, a, v, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		host.xfer(1'b0, a, 32'h0, v);
	endtask
	// Released data lines flip so a stale byte cannot look valid
	task automatic push(input logic [7:0] v);
		rx_valid_i <= 1'b1;
		rx_data_i  <= v;
		@(posedge clk_i);
		rx_valid_i <= 1'b0;
		rx_data_i  <= ~v;
		@(posedge clk_i);
		if (rxq.size() < 16)
			rxq.push_back(v);
	endtask
	task automatic pull;
		rd(ufd_pkg::ADR_DATA, q);
		d = rxq.pop_front();
		`CHK("rx data", d, q[7:0])
	endtask
	task automatic wait_st(input int b, input logic v);
		for (n = 0; n < 3000; n++) begin
			rd(ufd_pkg::ADR_STATUS, q);
			if (q[b] === v || host.hangs != 0)
				break;
			repeat (10) @(posedge clk_i);
		end
		if (n == 3000 || host.hangs != 0) begin
			fails++;
			close_out();
		end
	endtask

	initial begin
		n = $urandom(32'h29c0);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(ufd_pkg::ADR_IIR, q);
		`CHK("iir", 8'h01, q[7:0])
		`CHK("tx req", 1'b1, txreq)
		wr(ufd_pkg::ADR_DIV, 32'h1);
		wr(ufd_pkg::ADR_IER, 32'h1);
		push(8'h5a);
		wr(ufd_pkg::ADR_IIR, 32'h01);
		rxq.delete();
		rd(ufd_pkg::ADR_STATUS, q);
		`CHK("rx count", 5'h00, q[12:8])
		for (int t = 0; t < 4; t++) begin
			wr(ufd_pkg::ADR_IIR, {24'h0, t[1:0], 6'h03});
			rd(ufd_pkg::ADR_STATUS, q);
			`CHK("rx count", 5'h00, q[12:8])
			rd(ufd_pkg::ADR_IIR, q);
			`CHK("fifo on", 2'h3, q[7:6])
			for (int i = 0; i < 17; i++) begin
				if (i == lvl[t] - 1)
					`CHK("intr", 1'b0, intr)
				push(8'($urandom));
				if (i == lvl[t] - 1) begin
					repeat (2) @(posedge clk_i);
					`CHK("intr", 1'b1, intr)
					rd(ufd_pkg::ADR_IIR, q);
					`CHK("iir id", ufd_pkg::ID_RX_DATA, q[3:0])
				end
			end
			rd(ufd_pkg::ADR_STATUS, q);
			`CHK("overrun", 1'b1, q[0])
			`CHK("rx count", 5'h10, q[12:8])
			repeat (4) pull;
			rxq.delete();
		end
		wr(ufd_pkg::ADR_IIR, 32'hc3);
		repeat (2) push(8'($urandom));
		repeat (30) @(posedge clk_i);
		`CHK("intr", 1'b0, intr)
		repeat (15) @(posedge clk_i);
		`CHK("intr", 1'b1, intr)
		rd(ufd_pkg::ADR_IIR, q);
		`CHK("iir id", ufd_pkg::ID_TIMEOUT, q[3:0])
		push(8'($urandom));
		@(posedge clk_i);
		`CHK("intr", 1'b0, intr)
		repeat (45) @(posedge clk_i);
		`CHK("intr", 1'b1, intr)
		pull;
		`CHK("intr", 1'b0, intr)
		repeat (2) pull;
		wr(ufd_pkg::ADR_IIR, 32'h4b);
		repeat (3) push(8'($urandom));
		repeat (2) @(posedge clk_i);
		`CHK("rx req", 1'b0, rxreq)
		push(8'($urandom));
		repeat (2) @(posedge clk_i);
		`CHK("rx req", 1'b1, rxreq)
		repeat (3) pull;
		`CHK("rx req", 1'b1, rxreq)
		pull;
		`CHK("rx req", 1'b0, rxreq)
		// Slow line so the transmit FIFO can be filled to the brim
		wr(ufd_pkg::ADR_DIV, 32'd100);
		repeat (17) wr(ufd_pkg::ADR_DATA, $urandom);
		@(posedge clk_i);
		`CHK("tx req", 1'b0, txreq)
		wr(ufd_pkg::ADR_DATA, $urandom);
		rd(ufd_pkg::ADR_STATUS, q);
		`CHK("tx full", 1'b1, q[1])
		`CHK("tx count", 5'h10, q[20:16])
		wait_st(1, 1'b0);
		`CHK("tx req", 1'b1, txreq)
		wr(ufd_pkg::ADR_DATA, $urandom);
		rd(ufd_pkg::ADR_STATUS, q);
		`CHK("tx count", 5'h10, q[20:16])
		wait_st(3, 1'b1);
		wr(ufd_pkg::ADR_DIV, 32'h1);
		wr(ufd_pkg::ADR_IIR, 32'h01);
		wr(ufd_pkg::ADR_IER, 32'h2);
		repeat (2) @(posedge clk_i);
		`CHK("intr", 1'b1, intr)
		wr(ufd_pkg::ADR_DATA, $urandom);
		`CHK("intr", 1'b0, intr)
		repeat (3) @(posedge clk_i);
		`CHK("intr", 1'b0, intr)
		repeat (20) @(posedge clk_i);
		`CHK("intr", 1'b1, intr)
		// Frame bits looked at mid-cycle, clear of the launching edge
		d = 8'($urandom);
		wr(ufd_pkg::ADR_DATA, {24'h0, d});
		for (int b = 0; b < 9; b++) begin
			@(negedge clk_i);
			`CHK("serial", (b == 8) ? 1'b1 : d[b], serial_out)
		end
		@(posedge clk_i);
		repeat (3) wr(ufd_pkg::ADR_DATA, $urandom);
		wait_st(3, 1'b1);
		`CHK("intr", 1'b1, intr)
		push(8'h3c);
		wr(ufd_pkg::ADR_IIR, 32'h00);
		rd(ufd_pkg::ADR_IIR, q);
		`CHK("fifo off", 2'h0, q[7:6])
		rd(ufd_pkg::ADR_STATUS, q);
		`CHK("rx count", 5'h00, q[12:8])
		wr(8'h20, 32'hffffffff);
		rd(8'h20, q);
		`CHK("unmapped", 32'h0, q)
		close_out();
	end
endmodule
